/* File: core/purs_map.vh */
// register map, reset values and timing constants of the power-up reset sequencer
`ifndef PURS_MAP_VH
`define PURS_MAP_VH
// apb byte addresses
// power control flags: word index 08e, byte address four times the index
`define PURS_IDX_PCTRL       12'h08e
`define PURS_ADDR_PCTRL      12'h238
`define PURS_ADDR_CTRL       12'h000
`define PURS_ADDR_STATUS     12'h004
`define PURS_ADDR_IRQ_STAT   12'h008
`define PURS_ADDR_IRQ_MASK   12'h00c
`define PURS_ADDR_PCL        12'h010
`define PURS_ADDR_SREG       12'h014
`define PURS_ADDR_OPTION     12'h018
`define PURS_ADDR_TRIS       12'h01c
`define PURS_ADDR_INTCTL     12'h020
`define PURS_ADDR_PIFLAG     12'h024
`define PURS_ADDR_PR2        12'h028
`define PURS_ADDR_PCH        12'h02c
// reset values
`define PURS_RST_PCL         8'h00
`define PURS_RST_SREG_POR    8'h18
`define PURS_RST_OPTION      8'hff
`define PURS_RST_TRIS        8'h3f
`define PURS_TRIS_MASK       8'h3f
`define PURS_RST_INTCTL      8'h00
`define PURS_RST_PIFLAG      8'h00
`define PURS_PIFLAG_MASK     8'h7b
`define PURS_RST_PR2         8'hff
`define PURS_RST_PCH         8'h00
`define PURS_PCH_MASK        8'h1f
`define PURS_INT_VECTOR      8'h04
// status register flag positions and the interrupt control enable bit
`define PURS_SREG_TO_BIT     4
`define PURS_SREG_PD_BIT     3
`define PURS_SREG_GIE_BIT    7
// timing: 64 ms at the rc oscillator tick rate
`define PURS_PUT_MS          64
`define PURS_RC_HZ           31000
`define PURS_PUT_TICKS       ((`PURS_PUT_MS * `PURS_RC_HZ) / 1000)
`define PURS_RC_DIV          806
// reset cause codes
`define PURS_CAUSE_NONE      3'd0
`define PURS_CAUSE_POR       3'd1
`define PURS_CAUSE_BOR       3'd2
`define PURS_CAUSE_PIN       3'd3
`define PURS_CAUSE_WDT       3'd4
`define PURS_CAUSE_WAKE      3'd5
`endif

/* File: core/purs_sync.v */
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module purs_sync #(
    parameter WIDTH = 1
) (
    input  wire             ref_clk_in,
    input  wire             reset_n_in,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    // first stage feeds only the second
    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end
    assign sync_out = sync_ff;
endmodule // purs_sync

/* File: core/purs_put_timer.v */
// power-up timer counting rc oscillator ticks
`timescale 1ns/10ps
module purs_put_timer #(
    parameter TICKS = 1984
) (
    input  wire ref_clk_in,
    input  wire reset_n_in,
    input  wire start_in,
    input  wire rc_tick_in,
    output wire busy_out
);
    reg [31:0] count_ff;

    // load on start, count down on rc ticks only
    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            count_ff <= 32'h0000_0000;
        end else if (start_in) begin
            count_ff <= TICKS;
        end else if (rc_tick_in && count_ff != 32'h0000_0000) begin
            count_ff <= count_ff - 32'h0000_0001;
        end
    end
    assign busy_out = (count_ff != 32'h0000_0000);
endmodule // purs_put_timer

/* File: core/purs_sequencer.v */
// power-up reset sequencer with apb registers and interrupt
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`include "purs_map.vh"
// What this block does
// [R1] timer runs only after power-on or brown-out
// [R2] timer ticks from internal rc oscillator; here a tick from ref_clk_in divided by RC_DIV
// [R3] core reset held while timer runs
// [R4] fuse set disables timer, cleared enables
// [R5] fuse set disables timer on brown-out too
// [R6] pc low clears on resets, wake continues
// [R7] interrupt wake with enable loads vector
// [R8] status 0001 1xxx on power-on, flags vary
// [R9] brown-out flag cleared by brown-out and by power-on
// [R10] option all ones on resets, kept wake
// [R11] pin direction six ones on reset
// [R12] interrupt registers clear, wake keeps them but irq wake sets pir_ff bit 0
// [R13] timer2 period all ones on resets and on wake
// [R14] pc high five bits clear, kept wake
// [R15] low supply during reset forces power-on
// [R16] pin ignored when enable fuse cleared
// [R17] watchdog reset never drives pin low
// [R18] release after requests gone and timer done
// [R19] timer terminal count is a parameter
module purs_sequencer #(
    parameter PUT_TICKS = `PURS_PUT_TICKS,
    parameter RC_DIV    = `PURS_RC_DIV
) (
    input  wire        ref_clk_in,
    input  wire        reset_n_in,
    input  wire        por_req_in,
    input  wire        bor_req_in,
    input  wire        ext_pin_in,
    input  wire        wdt_req_in,
    input  wire        vdd_low_in,
    input  wire        wake_req_in,
    input  wire        wake_by_irq_in,
    input  wire        put_disable_fuse_in,
    input  wire        ext_reset_enable_fuse_in,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    output wire        core_reset_out,
    output wire        ext_pin_oe_out,
    output wire        irq_out
);
    // synchronised request pins
    wire [6:0] req_s;
    wire       por_s  = req_s[0];
    wire       bor_s  = req_s[1];
    wire       pin_s  = req_s[2];
    wire       wdt_s  = req_s[3];
    wire       vlow_s = req_s[4];
    wire       wake_s = req_s[5];
    wire       wirq_s = req_s[6];

    purs_sync #(.WIDTH(7)) u_sync (
        .ref_clk_in (ref_clk_in),
        .reset_n_in (reset_n_in),
        .async_in   ({wake_by_irq_in, wake_req_in, vdd_low_in, wdt_req_in,
                      ext_pin_in, bor_req_in, por_req_in}),
        .sync_out   (req_s)
    );

    // rc oscillator tick divider, derived from ref_clk_in divided by RC_DIV
    reg [15:0] rc_div_ff;
    wire       rc_tick = (rc_div_ff == 16'h0000);
    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            rc_div_ff <= 16'h0000;
        end else if (rc_tick) begin
            rc_div_ff <= RC_DIV[15:0] - 16'h0001; // see [R2]
        end else begin
            rc_div_ff <= rc_div_ff - 16'h0001;
        end
    end

    // cause decode with priority power-on first
    wire pin_req   = pin_s && ext_reset_enable_fuse_in;           // see [R16]
    wire full_por  = por_s || ((pin_req || wdt_s || bor_s) && vlow_s); // see [R15]
    wire any_req   = full_por || bor_s || pin_req || wdt_s;
    wire put_start = (full_por || bor_s) && !put_disable_fuse_in; // see [R1] [R4]
    wire put_busy;

    purs_put_timer #(.TICKS(PUT_TICKS)) u_put (
        .ref_clk_in (ref_clk_in),
        .reset_n_in (reset_n_in),
        .start_in   (put_start),
        .rc_tick_in (rc_tick),                                    // see [R2]
        .busy_out   (put_busy)
    );

    // held while any reset request or timer active, not on wake
    reg core_rst_ff;
    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            core_rst_ff <= 1'b1;
        end else begin
            core_rst_ff <= any_req || put_start || put_busy;       // see [R3] [R18]
        end
    end
    assign core_reset_out = core_rst_ff;
    assign ext_pin_oe_out = 1'b0;                                 // see [R17]

    // core registers
    reg  [7:0] pcl_ff, sreg_ff, opt_ff, tris_ff, intc_ff, pir_ff, pr2_ff, pch_ff;
    reg  [7:0] power_control_flags_ff;
    reg  [2:0] cause_ff;
    reg  [1:0] irq_stat_ff, irq_mask_ff;
    reg        wake_d_ff;
    wire       wake_ev  = wake_s && !wake_d_ff && !any_req;
    wire       wr       = psel && penable && pwrite;
    wire       global_interrupt_enable      = intc_ff[`PURS_SREG_GIE_BIT];
    wire [1:0] events   = {wake_ev, any_req && !core_rst_ff};

    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            wake_d_ff <= 1'b0;
        end else begin
            wake_d_ff <= wake_s;
        end
    end

    // reset and wake loading, else software writes
    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            pcl_ff   <= `PURS_RST_PCL;
            sreg_ff  <= `PURS_RST_SREG_POR;
            opt_ff   <= `PURS_RST_OPTION;
            tris_ff  <= `PURS_RST_TRIS;
            intc_ff  <= `PURS_RST_INTCTL;
            pir_ff   <= `PURS_RST_PIFLAG;
            pr2_ff   <= `PURS_RST_PR2;
            pch_ff   <= `PURS_RST_PCH;
            power_control_flags_ff  <= 8'h00;
            cause_ff <= `PURS_CAUSE_NONE;
        end else if (any_req) begin
            pcl_ff  <= `PURS_RST_PCL;                              // see [R6]
            opt_ff  <= `PURS_RST_OPTION;                           // see [R10]
            tris_ff <= `PURS_RST_TRIS;                             // see [R11]
            intc_ff <= `PURS_RST_INTCTL;                           // see [R12]
            pir_ff  <= `PURS_RST_PIFLAG;
            pr2_ff  <= `PURS_RST_PR2;                              // see [R13]
            pch_ff  <= `PURS_RST_PCH;                              // see [R14]
            if (full_por) begin
                sreg_ff  <= `PURS_RST_SREG_POR;                    // see [R8]
                power_control_flags_ff  <= 8'h00;                                 // see [R9]
                cause_ff <= `PURS_CAUSE_POR;
            end else begin
                // timeout set, power-down set except watchdog clears timeout
                sreg_ff <= {3'b000, !wdt_s, 1'b1, sreg_ff[2:0]};
                if (bor_s) begin
                    power_control_flags_ff  <= {power_control_flags_ff[7:1], 1'b0};              // see [R9]
                    cause_ff <= `PURS_CAUSE_BOR;
                end else if (wdt_s) begin
                    cause_ff <= `PURS_CAUSE_WDT;
                end else begin
                    cause_ff <= `PURS_CAUSE_PIN;
                end
            end
        end else if (wake_ev) begin
            cause_ff <= `PURS_CAUSE_WAKE;
            pr2_ff   <= `PURS_RST_PR2;                             // see [R13]
            // wake keeps registers except pr2, pc low and, on irq wake, pir_ff bit 0; clears power-down flag, timeout follows irq cause
            sreg_ff[`PURS_SREG_PD_BIT] <= 1'b0;                    // see [R8]
            sreg_ff[`PURS_SREG_TO_BIT] <= wirq_s;
            if (wirq_s && global_interrupt_enable) begin
                pcl_ff <= `PURS_INT_VECTOR;                        // see [R7]
            end else begin
                pcl_ff <= pcl_ff + 8'h01;                          // see [R6]
            end
            if (wirq_s) begin
                pir_ff[0] <= 1'b1;                                 // see [R12]
            end
        end else if (wr) begin
            case (paddr)
                `PURS_ADDR_PCTRL:  power_control_flags_ff <= {6'b000000, pwdata[1:0]};
                `PURS_ADDR_PCL:    pcl_ff  <= pwdata[7:0];
                `PURS_ADDR_SREG:   sreg_ff <= pwdata[7:0];
                `PURS_ADDR_OPTION: opt_ff  <= pwdata[7:0];
                `PURS_ADDR_TRIS:   tris_ff <= pwdata[7:0] & `PURS_TRIS_MASK;
                `PURS_ADDR_INTCTL: intc_ff <= pwdata[7:0];
                `PURS_ADDR_PIFLAG: pir_ff  <= pwdata[7:0] & `PURS_PIFLAG_MASK;
                `PURS_ADDR_PR2:    pr2_ff  <= pwdata[7:0];
                `PURS_ADDR_PCH:    pch_ff  <= pwdata[7:0] & `PURS_PCH_MASK; // see [R14]
                default:           pcl_ff  <= pcl_ff;
            endcase
        end
    end

    // sticky interrupt status, set wins over write-one clear
    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            irq_stat_ff <= 2'b00;
            irq_mask_ff <= 2'b00;
        end else begin
            if (wr && paddr == `PURS_ADDR_IRQ_MASK) begin
                irq_mask_ff <= pwdata[1:0];
            end
            if (wr && paddr == `PURS_ADDR_IRQ_STAT) begin
                irq_stat_ff <= (irq_stat_ff & ~pwdata[1:0]) | events;
            end else begin
                irq_stat_ff <= irq_stat_ff | events;
            end
        end
    end
    assign irq_out = |(irq_stat_ff & irq_mask_ff);

    // apb read mux, zero-wait, error on unmapped
    reg hit;
    always @* begin
        hit = 1'b1;
        case (paddr)
            `PURS_ADDR_PCTRL:    prdata = {24'h00_0000, power_control_flags_ff};
            `PURS_ADDR_CTRL:     prdata = {30'h0000_0000, ext_reset_enable_fuse_in,
                                           put_disable_fuse_in};
            `PURS_ADDR_STATUS:   prdata = {27'h000_0000, cause_ff, put_busy, core_rst_ff};
            `PURS_ADDR_IRQ_STAT: prdata = {30'h0000_0000, irq_stat_ff};
            `PURS_ADDR_IRQ_MASK: prdata = {30'h0000_0000, irq_mask_ff};
            `PURS_ADDR_PCL:      prdata = {24'h00_0000, pcl_ff};
            `PURS_ADDR_SREG:     prdata = {24'h00_0000, sreg_ff};
            `PURS_ADDR_OPTION:   prdata = {24'h00_0000, opt_ff};
            `PURS_ADDR_TRIS:     prdata = {24'h00_0000, tris_ff};
            `PURS_ADDR_INTCTL:   prdata = {24'h00_0000, intc_ff};
            `PURS_ADDR_PIFLAG:   prdata = {24'h00_0000, pir_ff};
            `PURS_ADDR_PR2:      prdata = {24'h00_0000, pr2_ff};
            `PURS_ADDR_PCH:      prdata = {24'h00_0000, pch_ff};
            default: begin
                prdata = 32'h0000_0000;
                hit    = 1'b0;
            end
        endcase
    end
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
endmodule // purs_sequencer

/* File: tb/purs_supply_model.sv */
// behavioural supply monitors, reset pin, watchdog and wake source
`timescale 1ns/10ps
module purs_supply_model (
    input  wire ref_clk_in,
    output reg  por_out,
    output reg  bor_out,
    output reg  pin_out,
    output reg  wdt_out,
    output reg  vdd_low_out,
    output reg  wake_out,
    output reg  wake_irq_out
);
    initial {wake_irq_out, wake_out, vdd_low_out, wdt_out, pin_out, bor_out, por_out} = 7'h00;
    // raise the selected lines for n cycles; the irq wake cause is a level and stays
    task pulse(input logic [6:0] sel, input int n);
        begin
            @(posedge ref_clk_in);
            {wake_irq_out, wake_out, vdd_low_out, wdt_out, pin_out, bor_out, por_out} <= sel;
            repeat (n) @(posedge ref_clk_in);
            {wake_out, vdd_low_out, wdt_out, pin_out, bor_out, por_out} <= 6'h00;
        end
    endtask
endmodule // purs_supply_model

/* File: tb/purs_sequencer_assertions.sv */
// concurrent checks on the ports of the reset sequencer
`timescale 1ns/10ps
module purs_sequencer_assertions #(
    parameter PUT_TICKS = 1984,
    parameter RC_DIV    = 806
) (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire por_req_in,
    input wire bor_req_in,
    input wire ext_pin_in,
    input wire wdt_req_in,
    input wire vdd_low_in,
    input wire wake_req_in,
    input wire put_disable_fuse_in,
    input wire ext_reset_enable_fuse_in,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire core_reset_out,
    input wire ext_pin_oe_out
);
    localparam int MIN_PUT = PUT_TICKS * RC_DIV;
    reg  [31:0] gone_cnt_ff;
    reg         put_cause_ff;
    wire        any_req = por_req_in | bor_req_in | wdt_req_in | vdd_low_in | wake_req_in
                          | (ext_pin_in & ext_reset_enable_fuse_in);
    // cycles since the last request and whether that was a supply event
    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            gone_cnt_ff  <= 32'h0000_0000;
            put_cause_ff <= 1'b0;
        end else begin
            gone_cnt_ff  <= any_req ? 32'h0000_0000 : gone_cnt_ff + 32'h0000_0001;
            // low supply during a pin or watchdog reset counts as a power-on cause
            put_cause_ff <= (por_req_in | bor_req_in | (vdd_low_in & (wdt_req_in |
                            (ext_pin_in & ext_reset_enable_fuse_in)))) ? 1'b1 :
                            (any_req ? 1'b0 : put_cause_ff);
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    chk_por_holds: assert property (por_req_in [*4] |-> core_reset_out)
        else $error("power-on request did not hold core reset");
    chk_bor_holds: assert property (bor_req_in [*4] |-> core_reset_out)
        else $error("brown-out request did not hold core reset");
    chk_wdt_holds: assert property ($rose(wdt_req_in) ##1 wdt_req_in [*2] |=> core_reset_out)
        else $error("watchdog request did not reset core");
    chk_pin_ignored: assert property ((!ext_reset_enable_fuse_in && !core_reset_out &&
        !(por_req_in | bor_req_in | wdt_req_in | vdd_low_in | wake_req_in)) [*4] |=> !core_reset_out)
        else $error("reset pin acted with enable fuse cleared");
    chk_pin_undriven: assert property (wdt_req_in |-> !ext_pin_oe_out)
        else $error("reset pin driven during watchdog reset");
    chk_release_clean: assert property ($fell(core_reset_out) |->
        !(por_req_in | bor_req_in | wdt_req_in)) else $error("core released with request present");
    chk_put_min: assert property ($fell(core_reset_out) && put_cause_ff &&
        !put_disable_fuse_in |-> gone_cnt_ff >= MIN_PUT) else $error("power-up delay too short");
    chk_put_absent: assert property ($fell(core_reset_out) &&
        (!put_cause_ff || put_disable_fuse_in) |-> gone_cnt_ff <= 6)
        else $error("power-up delay ran where it must not");
    chk_zero_wait: assert property (psel && penable |-> pready) else $error("apb wait inserted");
    chk_err_access: assert property (pslverr |-> psel && penable) else $error("stray slave error");
    cov_release: cover property ($fell(core_reset_out));
    cov_wake: cover property ($rose(wake_req_in));
    cov_err: cover property (pslverr);
endmodule // purs_sequencer_assertions
bind purs_sequencer purs_sequencer_assertions #(.PUT_TICKS(PUT_TICKS), .RC_DIV(RC_DIV)) u_chk (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .por_req_in(por_req_in),
    .bor_req_in(bor_req_in), .ext_pin_in(ext_pin_in), .wdt_req_in(wdt_req_in),
    .vdd_low_in(vdd_low_in), .wake_req_in(wake_req_in), .put_disable_fuse_in(put_disable_fuse_in),
    .ext_reset_enable_fuse_in(ext_reset_enable_fuse_in), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .core_reset_out(core_reset_out),
    .ext_pin_oe_out(ext_pin_oe_out));

/* File: tb/tb.sv */
// self-checking bench for the power-up reset sequencer
`timescale 1ns/10ps
`include "purs_map.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
    reg         ref_clk_in = 1'b0;
    reg         reset_n_in = 1'b0;
    reg         put_dis = 1'b0;
    reg         pin_en = 1'b1;
    reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0000_0000, rd;
    wire        pready, pslverr, core_reset_out, ext_pin_oe_out, irq_out;
    wire [31:0] prdata;
    wire        por, bor, pin, wdt, vlow, wake, wake_irq;
    integer     error_cnt = 0, cmp_count = 0, rel_n;
    always #20 ref_clk_in = ~ref_clk_in;
    purs_supply_model mdl (.ref_clk_in(ref_clk_in), .por_out(por), .bor_out(bor), .pin_out(pin),
        .wdt_out(wdt), .vdd_low_out(vlow), .wake_out(wake), .wake_irq_out(wake_irq));
    purs_sequencer #(.PUT_TICKS(3), .RC_DIV(2)) DUT (.ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in), .por_req_in(por), .bor_req_in(bor), .ext_pin_in(pin),
        .wdt_req_in(wdt), .vdd_low_in(vlow), .wake_req_in(wake), .wake_by_irq_in(wake_irq),
        .put_disable_fuse_in(put_dis), .ext_reset_enable_fuse_in(pin_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .core_reset_out(core_reset_out),
        .ext_pin_oe_out(ext_pin_oe_out), .irq_out(irq_out));
    // one apb transfer held until pready is sampled high, then one idle cycle
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge ref_clk_in);
            penable <= 1'b1;
            do begin
                @(posedge ref_clk_in);
            end while (pready !== 1'b1);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge ref_clk_in);
        end
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
        begin
            apb(1'b0, a, 32'h0000_0000);
            `CHK(nm, e, rd)
        end
    endtask
    // wait for core release, counting cycles after the request dropped
    task wait_rel;
        begin
            rel_n = 0;
            while (core_reset_out !== 1'b0 && rel_n < 200) begin
                @(posedge ref_clk_in);
                rel_n++;
            end
            `CHK("core release", 1'b0, core_reset_out)
        end
    endtask
    task wr_set;
        begin
            apb(1'b1, `PURS_ADDR_OPTION, 32'h0000_005a);
            apb(1'b1, `PURS_ADDR_TRIS, 32'h0000_0005);
            apb(1'b1, `PURS_ADDR_PCH, 32'h0000_00ff);
            apb(1'b1, `PURS_ADDR_PCTRL, 32'h0000_0001);
            apb(1'b1, `PURS_ADDR_PR2, 32'h0000_0012);
            apb(1'b1, `PURS_ADDR_INTCTL, 32'h0000_0080);
            apb(1'b1, `PURS_ADDR_PCL, 32'h0000_0033);
        end
    endtask
    task t_por;
        begin
            mdl.pulse(7'h01, 6);
            wait_rel;
            `CHK("put delay", 1'b1, rel_n >= 8)
            rdchk(`PURS_ADDR_PCL, 32'h0000_0000, "pcl");
            apb(1'b0, `PURS_ADDR_SREG, 32'h0000_0000);
            `CHK("sreg", 5'h03, rd[7:3])
            rdchk(`PURS_ADDR_PCTRL, 32'h0000_0000, "power_control_flags");
            rdchk(`PURS_ADDR_OPTION, 32'h0000_00ff, "option");
            rdchk(`PURS_ADDR_TRIS, 32'h0000_003f, "tris");
            rdchk(`PURS_ADDR_INTCTL, 32'h0000_0000, "intctl");
            rdchk(`PURS_ADDR_PIFLAG, 32'h0000_0000, "piflag");
            rdchk(`PURS_ADDR_PR2, 32'h0000_00ff, "pr2");
            rdchk(`PURS_ADDR_PCH, 32'h0000_0000, "pch");
        end
    endtask
    task t_wdt;
        begin
            wr_set;
            rdchk(`PURS_ADDR_PCH, 32'h0000_001f, "pch bits");
            mdl.pulse(7'h08, 6);
            `CHK("pin oe", 1'b0, ext_pin_oe_out)
            wait_rel;
            `CHK("no delay", 1'b1, rel_n <= 5)
            rdchk(`PURS_ADDR_PCL, 32'h0000_0000, "pcl");
            rdchk(`PURS_ADDR_OPTION, 32'h0000_00ff, "option");
            rdchk(`PURS_ADDR_TRIS, 32'h0000_003f, "tris");
            rdchk(`PURS_ADDR_PCH, 32'h0000_0000, "pch");
            rdchk(`PURS_ADDR_INTCTL, 32'h0000_0000, "intctl");
            rdchk(`PURS_ADDR_PR2, 32'h0000_00ff, "pr2 wdt");
            rdchk(`PURS_ADDR_PCTRL, 32'h0000_0001, "power_control_flags kept");
            rdchk(`PURS_ADDR_STATUS, {27'h000_0000, `PURS_CAUSE_WDT, 2'b00}, "cause wdt");
            apb(1'b0, `PURS_ADDR_SREG, 32'h0000_0000);
            `CHK("sreg wdt", 2'b01, rd[4:3])
        end
    endtask
    task t_bor;
        begin
            mdl.pulse(7'h02, 6); // timer left enabled with brown-out
            wait_rel;
            `CHK("bor delay", 1'b1, rel_n >= 8)
            rdchk(`PURS_ADDR_PCTRL, 32'h0000_0000, "power_control_flags bor");
            put_dis <= 1'b1;
            wr_set;
            mdl.pulse(7'h18, 6);
            wait_rel;
            `CHK("fuse off", 1'b1, rel_n <= 5)
            rdchk(`PURS_ADDR_CTRL, 32'h0000_0003, "fuse readback");
            apb(1'b0, `PURS_ADDR_SREG, 32'h0000_0000);
            `CHK("sreg por", 2'b11, rd[4:3])
            rdchk(`PURS_ADDR_PCTRL, 32'h0000_0000, "power_control_flags por");
            put_dis <= 1'b0;
        end
    endtask
    task t_wake;
        begin
            wr_set;
            apb(1'b1, `PURS_ADDR_IRQ_STAT, 32'h0000_0003);
            apb(1'b1, `PURS_ADDR_IRQ_MASK, 32'h0000_0002);
            `CHK("irq idle", 1'b0, irq_out)
            mdl.pulse(7'h60, 4);
            repeat (6) @(posedge ref_clk_in);
            `CHK("irq wake", 1'b1, irq_out)
            rdchk(`PURS_ADDR_PCL, 32'h0000_0004, "vector");
            rdchk(`PURS_ADDR_OPTION, 32'h0000_005a, "option kept");
            rdchk(`PURS_ADDR_TRIS, 32'h0000_0005, "tris kept");
            rdchk(`PURS_ADDR_PR2, 32'h0000_00ff, "pr2 wake");
            rdchk(`PURS_ADDR_PCH, 32'h0000_001f, "pch kept");
            rdchk(`PURS_ADDR_INTCTL, 32'h0000_0080, "intctl kept");
            rdchk(`PURS_ADDR_PIFLAG, 32'h0000_0001, "wake flag");
            apb(1'b0, `PURS_ADDR_SREG, 32'h0000_0000);
            `CHK("sreg wake", 2'b10, rd[4:3])
            apb(1'b1, `PURS_ADDR_IRQ_MASK, 32'h0000_0000);
            `CHK("irq masked", 1'b0, irq_out)
            apb(1'b1, `PURS_ADDR_IRQ_MASK, 32'h0000_0002);
            apb(1'b1, `PURS_ADDR_IRQ_STAT, 32'h0000_0002);
            `CHK("irq cleared", 1'b0, irq_out)
            mdl.pulse(7'h20, 4);
            repeat (6) @(posedge ref_clk_in);
            rdchk(`PURS_ADDR_PCL, 32'h0000_0005, "next pc");
        end
    endtask
    task t_pin;
        begin
            pin_en <= 1'b0;
            mdl.pulse(7'h04, 6);
            `CHK("pin ignored", 1'b0, core_reset_out)
            pin_en <= 1'b1;
            mdl.pulse(7'h04, 6);
            `CHK("pin reset", 1'b1, core_reset_out)
            wait_rel;
            apb(1'b0, 12'h3f0, 32'h0000_0000);
            `CHK("unmapped err", 1'b1, err)
            `CHK("unmapped data", 32'h0000_0000, rd)
        end
    endtask
    task close_out;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
            if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // main sequence after six cycles of reset
    initial begin
        repeat (6) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        @(posedge ref_clk_in);
        t_por;
        t_wdt;
        t_bor;
        t_wake;
        t_pin;
        close_out;
    end
    // watchdog for a hung run
    initial begin
        #400000;
        error_cnt++;
        close_out;
    end
endmodule // tb
